// ===== logic/hlm_pkg.sv
// Package: register map, field layout, reset values and types of the left headphone mix block
package hlm_pkg;

  // ************************************************************
  // Register offsets on the codec control port
  // ************************************************************
  localparam logic [7:0] HLM_OFS_LINE2_LEFT = 8'h2D;
  localparam logic [7:0] HLM_OFS_PREAMP_LEFT = 8'h2E;
  localparam logic [7:0] HLM_OFS_CONV_LEFT = 8'h2F;
  localparam logic [7:0] HLM_OFS_LINE2_RIGHT = 8'h30;
  localparam logic [7:0] HLM_OFS_PREAMP_RIGHT = 8'h31;
  localparam logic [7:0] HLM_OFS_CONV_RIGHT = 8'h32;
  localparam logic [7:0] HLM_OFS_LEVEL_CTRL = 8'h33;

  // ************************************************************
  // Field positions and widths
  // ************************************************************
  localparam int HLM_NUM_SRC = 6;
  localparam int HLM_ATT_W = 7;
  localparam int HLM_LVL_W = 4;
  localparam int HLM_ROUTE_BIT = 7;
  localparam int HLM_ATT_MSB = 6;
  localparam int HLM_LVL_MSB = 7;
  localparam int HLM_LVL_LSB = 4;
  localparam int HLM_UNMUTE_BIT = 3;
  localparam int HLM_HIZ_BIT = 2;
  localparam int HLM_PEND_BIT = 1;
  localparam int HLM_PWR_BIT = 0;

  // ************************************************************
  // Reset values and codes
  // ************************************************************
  localparam logic [7:0] HLM_SRC_RST = 8'h00;
  localparam logic [7:0] HLM_LVL_RST = 8'h04;
  localparam logic HLM_PEND_RST = 1'h1;
  localparam logic [7:0] HLM_RD_UNMAPPED = 8'h00;
  localparam logic [6:0] HLM_ATT_MUTE_MIN = 7'h76;

  // ************************************************************
  // Gain slew timing: one code step per period
  // ************************************************************
  localparam int HLM_CLK_MHZ = 100;
  localparam int HLM_STEP_TIME_NS = 1000;
  localparam int HLM_STEP_CYCLES = (HLM_STEP_TIME_NS * HLM_CLK_MHZ) / 1000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [0:0] {
    HLM_SLEW_IDLE = 1'b0,
    HLM_SLEW_MOVE = 1'b1
  } hlm_slew_st_t;

  typedef struct packed {
    logic [HLM_NUM_SRC-1:0] route_en;
    logic [HLM_NUM_SRC-1:0][HLM_ATT_W-1:0] src_att;
    logic [HLM_NUM_SRC-1:0] src_mute;
    logic [HLM_LVL_W-1:0] level;
    logic unmute;
    logic hiz_pd;
    logic power_up;
  } hlm_analog_t;

  // Attenuation codes from 118 upward select mute
  function automatic logic hlm_att_is_mute(input logic [HLM_ATT_W-1:0] code);
    return code >= HLM_ATT_MUTE_MIN;
  endfunction

endpackage

// ===== logic/hlm_slew.sv
// One gain channel that walks its applied code one step per tick toward its target
`timescale 1ns/10ps
`default_nettype none

module hlm_slew #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Step timing
  input wire logic tick,
  // Programmed and applied code
  input wire logic [W-1:0] target,
  output logic [W-1:0] applied,
  output logic busy
);
  import hlm_pkg::*;

  // ************************************************************
  // Slew state
  // ************************************************************
  hlm_slew_st_t st_r;
  hlm_slew_st_t st_nxt;
  logic [W-1:0] app_r;
  logic [W-1:0] app_nxt;
  wire logic differs = (app_r != target);
  wire logic go_up = (target > app_r);

  // Next state: move while applied differs from target
  always_comb begin
    st_nxt = st_r;
    app_nxt = app_r;
    case (st_r)
      HLM_SLEW_IDLE: begin
        if (differs) begin
          st_nxt = HLM_SLEW_MOVE;
        end
      end
      HLM_SLEW_MOVE: begin
        if (!differs) begin
          st_nxt = HLM_SLEW_IDLE;
        end else if (tick) begin
          app_nxt = go_up ? W'(app_r + 1'b1) : W'(app_r - 1'b1);
        end
      end
      default: st_nxt = HLM_SLEW_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= HLM_SLEW_IDLE;
      app_r <= '0;
    end else begin
      st_r <= st_nxt;
      app_r <= app_nxt;
    end
  end

  assign applied = app_r;
  assign busy = differs; // Pending until the analog value matches

endmodule // hlm_slew

`default_nettype wire

// ===== logic/hlm_regs.sv
// Left headphone mix control registers with gain slewing toward the analog path
`timescale 1ns/10ps
`default_nettype none

module hlm_regs #(
  parameter int STEP_CYCLES = hlm_pkg::HLM_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port from the control bus decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Settings applied to the analog mixer and driver
  output hlm_pkg::hlm_analog_t analog
);
  import hlm_pkg::*;

  // ************************************************************
  // Address decode
  // ************************************************************
  wire logic hit_l2l = (reg_addr == HLM_OFS_LINE2_LEFT);
  wire logic hit_pgl = (reg_addr == HLM_OFS_PREAMP_LEFT);
  wire logic hit_cvl = (reg_addr == HLM_OFS_CONV_LEFT);
  wire logic hit_l2r = (reg_addr == HLM_OFS_LINE2_RIGHT);
  wire logic hit_pgr = (reg_addr == HLM_OFS_PREAMP_RIGHT);
  wire logic hit_cvr = (reg_addr == HLM_OFS_CONV_RIGHT);
  wire logic hit_lvl = (reg_addr == HLM_OFS_LEVEL_CTRL);
  wire logic [HLM_NUM_SRC-1:0] hit_src = {hit_cvr, hit_pgr, hit_l2r, hit_cvl, hit_pgl, hit_l2l};

  // ************************************************************
  // Source and level registers
  // ************************************************************
  logic [7:0] src_r [0:HLM_NUM_SRC-1];
  logic [7:0] lvl_r;
  logic pend_r;
  logic [7:0] rdata_r;
  hlm_analog_t ana_r;

  // Writes that change a gain field (source attenuation or level boost)
  wire logic [HLM_NUM_SRC-1:0] att_wr;
  wire logic lvl_gain_wr =
    reg_wr && hit_lvl && (reg_wdata[HLM_LVL_MSB:HLM_LVL_LSB] != lvl_r[HLM_LVL_MSB:HLM_LVL_LSB]);

  // Source registers: route bit and 7-bit attenuation, both read-write
  genvar gs;
  generate
    for (gs = 0; gs < HLM_NUM_SRC; gs++) begin : g_src
      assign att_wr[gs] =
        reg_wr && hit_src[gs] && (reg_wdata[HLM_ATT_MSB:0] != src_r[gs][HLM_ATT_MSB:0]);
      always_ff @(posedge clk) begin
        if (rst) begin
          src_r[gs] <= HLM_SRC_RST;
        end else if (reg_wr && hit_src[gs]) begin
          src_r[gs] <= reg_wdata;
        end
      end
    end
  endgenerate

  // Level register: boost, mute, hold mode, power; bit 1 is never stored
  always_ff @(posedge clk) begin
    if (rst) begin
      lvl_r <= HLM_LVL_RST;
    end else if (reg_wr && hit_lvl) begin
      lvl_r <= {reg_wdata[HLM_LVL_MSB:HLM_HIZ_BIT], 1'b0, reg_wdata[HLM_PWR_BIT]};
    end
  end

  // ************************************************************
  // Gain slewing toward the analog path
  // ************************************************************
  localparam int TICK_W = STEP_CYCLES > 1 ? $clog2(STEP_CYCLES) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STEP_CYCLES - 1);
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick_r;

  // Free-running step timer
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TICK_LAST);
      tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0 : TICK_W'(tick_cnt_r + 1'b1);
    end
  end

  logic [HLM_NUM_SRC-1:0][HLM_ATT_W-1:0] att_applied;
  logic [HLM_NUM_SRC-1:0] att_busy;
  logic [HLM_LVL_W-1:0] lvl_applied;
  logic lvl_busy;

  // One slewing channel per source attenuation
  genvar gc;
  generate
    for (gc = 0; gc < HLM_NUM_SRC; gc++) begin : g_slew
      hlm_slew #(
        .W(HLM_ATT_W)
      ) u_att (
        .clk(clk),
        .rst(rst),
        .tick(tick_r),
        .target(src_r[gc][HLM_ATT_MSB:0]),
        .applied(att_applied[gc]),
        .busy(att_busy[gc])
      );
    end
  endgenerate

  // Output boost slews the same way
  hlm_slew #(
    .W(HLM_LVL_W)
  ) u_lvl (
    .clk(clk),
    .rst(rst),
    .tick(tick_r),
    .target(lvl_r[HLM_LVL_MSB:HLM_LVL_LSB]),
    .applied(lvl_applied),
    .busy(lvl_busy)
  );

  // ************************************************************
  // Pending-gain status
  // ************************************************************
  // A new write wins over the channels reporting done in the same cycle
  wire logic pend_set = (|att_wr) || lvl_gain_wr;
  wire logic pend_nxt = pend_set || (|att_busy) || lvl_busy;

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r <= HLM_PEND_RST;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // ************************************************************
  // Read-back
  // ************************************************************
  wire logic [7:0] lvl_rd = {lvl_r[HLM_LVL_MSB:HLM_HIZ_BIT], pend_r, lvl_r[HLM_PWR_BIT]};
  logic [7:0] rd_mux;

  // Unmapped offsets read as zero
  assign rd_mux =
    hit_l2l ? src_r[0] :
    hit_pgl ? src_r[1] :
    hit_cvl ? src_r[2] :
    hit_l2r ? src_r[3] :
    hit_pgr ? src_r[4] :
    hit_cvr ? src_r[5] :
    hit_lvl ? lvl_rd :
    HLM_RD_UNMAPPED;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= HLM_RD_UNMAPPED;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end
  end

  // ************************************************************
  // Analog settings
  // ************************************************************
  hlm_analog_t ana_nxt;
  logic [HLM_NUM_SRC-1:0] route_nxt;
  logic [HLM_NUM_SRC-1:0] mute_nxt;

  // Route bits and mute decode per source
  always_comb begin
    for (int i = 0; i < HLM_NUM_SRC; i++) begin
      route_nxt[i] = src_r[i][HLM_ROUTE_BIT];
      mute_nxt[i] = hlm_att_is_mute(att_applied[i]);
    end
  end

  // Collect the applied values into the analog control word
  always_comb begin
    ana_nxt.route_en = route_nxt;
    ana_nxt.src_att = att_applied;
    ana_nxt.src_mute = mute_nxt;
    ana_nxt.level = lvl_applied;
    ana_nxt.unmute = lvl_r[HLM_UNMUTE_BIT];
    ana_nxt.hiz_pd = lvl_r[HLM_HIZ_BIT];
    ana_nxt.power_up = lvl_r[HLM_PWR_BIT];
  end

  // Registered drive toward the analog mixer
  always_ff @(posedge clk) begin
    if (rst) begin
      ana_r <= '{
        route_en: '0,
        src_att: '0,
        src_mute: '0,
        level: '0,
        unmute: HLM_LVL_RST[HLM_UNMUTE_BIT],
        hiz_pd: HLM_LVL_RST[HLM_HIZ_BIT],
        power_up: HLM_LVL_RST[HLM_PWR_BIT]
      };
    end else begin
      ana_r <= ana_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign analog = ana_r;

endmodule // hlm_regs

`default_nettype wire

// ===== verif/hlm_regs_properties.sv
// Checker of the left headphone mix register block
`timescale 1ns/10ps
`default_nettype none

module hlm_regs_chk #(
  parameter int STEP_CYCLES = hlm_pkg::HLM_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Analog settings
  input wire hlm_pkg::hlm_analog_t analog
);
  import hlm_pkg::*;

  // ********************
  // Decode helpers
  // ********************
  wire logic src_wr = reg_wr && reg_addr >= 8'h2D && reg_addr <= 8'h32;
  wire logic lvl_wr = reg_wr && reg_addr == 8'h33;
  wire logic [2:0] src_idx = 3'(reg_addr - 8'h2D);
  logic [5:0] mute_exp;

  // Mute expected from the applied attenuation
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      mute_exp[i] = analog.src_att[i] >= 7'h76;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  route_follow_a: assert property (
    src_wr |-> ##2 analog.route_en[$past(src_idx, 2)] == $past(reg_wdata[7], 2))
    else $error("route enable does not follow write");
  unmute_follow_a: assert property (
    lvl_wr |-> ##2 analog.unmute == $past(reg_wdata[3], 2))
    else $error("unmute does not follow write");
  hiz_follow_a: assert property (
    lvl_wr |-> ##2 analog.hiz_pd == $past(reg_wdata[2], 2))
    else $error("hold mode does not follow write");
  power_follow_a: assert property (
    lvl_wr |-> ##2 analog.power_up == $past(reg_wdata[0], 2))
    else $error("power does not follow write");
  mute_decode_a: assert property (analog.src_mute == mute_exp)
    else $error("source mute decode wrong");
  write_readback_a: assert property (
    src_wr ##1 (reg_rd && !reg_wr && reg_addr == $past(reg_addr))
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("read back differs from write");
  unmapped_read_a: assert property (
    reg_rd && (reg_addr < 8'h2D || reg_addr > 8'h33) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  slew_step_a: assert property (
    !$past(rst) |->
      (analog.src_att[0] - $past(analog.src_att[0])) inside {7'h00, 7'h01, 7'h7F})
    else $error("applied gain jumped");
endmodule // hlm_regs_chk

bind hlm_regs hlm_regs_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .analog(analog));

`default_nettype wire

// ===== verif/testbench.sv
// Self-checking testbench of the left headphone mix register block
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import hlm_pkg::*;

  // ********************
  // Signals and design
  // ********************
  localparam int STEP = 3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  hlm_analog_t analog;
  logic [7:0] rd_d;
  int error_cnt = 0;
  int n_compared = 0;

  // Clock of 10 ns
  always #5 clk = ~clk;

  hlm_regs #(.STEP_CYCLES(STEP)) DUT (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .analog(analog));

  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe; called right after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read strobe, data taken one cycle later
  task automatic rd(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    rd_d = reg_rdata;
  endtask

  // Poll the pending bit until all gains are applied
  task automatic wait_idle();
    int n = 0;
    rd(HLM_OFS_LEVEL_CTRL);
    while (rd_d[1] !== 1'b0 && n < 400) begin
      rd(HLM_OFS_LEVEL_CTRL);
      n++;
    end
    chk(8'(rd_d[1]), 8'h00);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    chk(8'({analog.unmute, analog.hiz_pd, analog.power_up}), 8'h02);
    chk(8'(analog.route_en), 8'h00);
    for (int i = 0; i < 7; i++) begin
      rd(HLM_OFS_LINE2_LEFT + 8'(i));
      chk(rd_d, (i == 6) ? 8'h04 : 8'h00);
    end
  endtask

  // Each source routed in turn with a slewed gain
  task automatic t_routes();
    for (int i = 0; i < 6; i++) begin
      wr(HLM_OFS_LINE2_LEFT + 8'(i), 8'h80 | 8'(i + 8));
      rd(HLM_OFS_LINE2_LEFT + 8'(i));
      chk(rd_d, 8'h80 | 8'(i + 8));
      chk(8'(analog.route_en), 8'((1 << (i + 1)) - 1));
      rd(HLM_OFS_LEVEL_CTRL);
      chk(rd_d, 8'h06);
      wait_idle();
      chk(8'(analog.src_att[i]), 8'(i + 8));
    end
  endtask

  // Boundary between the last gain and the mute codes
  task automatic t_mute();
    wr(HLM_OFS_LINE2_LEFT, 8'h76);
    wait_idle();
    chk(8'({analog.route_en[0], analog.src_mute[0]}), 8'h01);
    wr(HLM_OFS_LINE2_LEFT, 8'h75);
    wait_idle();
    chk(8'({analog.src_att[0], analog.src_mute[0]}), 8'hEA);
  endtask

  // Boost, mute, hold mode, status and power bits
  task automatic t_level();
    wr(HLM_OFS_LEVEL_CTRL, 8'h9F);
    rd(HLM_OFS_LEVEL_CTRL);
    chk(rd_d, 8'h9F);
    wait_idle();
    rd(HLM_OFS_LEVEL_CTRL);
    chk(rd_d, 8'h9D);
    chk(8'(analog.level), 8'h09);
    chk(8'({analog.unmute, analog.hiz_pd, analog.power_up}), 8'h07);
    wr(HLM_OFS_LEVEL_CTRL, 8'h9B);
    rd(HLM_OFS_LEVEL_CTRL);
    chk(rd_d, 8'h99);
    chk(8'(analog.hiz_pd), 8'h00);
  endtask

  // Offsets just outside the map
  task automatic t_unmapped();
    wr(8'h2C, 8'hFF);
    @(posedge clk);
    wr(8'h34, 8'hFF);
    rd(8'h2C);
    chk(rd_d, 8'h00);
    rd(8'h34);
    chk(rd_d, 8'h00);
    rd(HLM_OFS_PREAMP_LEFT);
    chk(rd_d, 8'h89);
  endtask

  // Reset in the middle of a gain ramp
  task automatic t_rst_mid();
    wr(HLM_OFS_CONV_RIGHT, 8'hFF);
    repeat (5) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(HLM_OFS_LEVEL_CTRL);
    chk(rd_d, 8'h06);
    rd(HLM_OFS_CONV_RIGHT);
    chk(rd_d, 8'h00);
    chk(8'(analog.route_en), 8'h00);
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_routes();
    t_mute();
    t_level();
    t_unmapped();
    t_rst_mid();
    final_report();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
endmodule // testbench

`default_nettype wire
